// [hdl/mcuid_cfg.svh]
`ifndef MCUID_CFG_SVH
`define MCUID_CFG_SVH

// word and field layout
`define MCUID_IW        14
`define MCUID_PCW       13
`define MCUID_F_GRP     13:12
`define MCUID_F_OP      11:8
`define MCUID_F_D       7
`define MCUID_F_FILE    6:0
`define MCUID_F_BOP     11:10
`define MCUID_F_BIT     9:7
`define MCUID_F_K8      7:0
`define MCUID_F_K11     10:0
`define MCUID_F_JSEL    11
`define MCUID_F_L2      11:10
`define MCUID_F_L3      11:9
`define MCUID_F_CTL     7:0
`define MCUID_MSB       7
`define MCUID_LSB       0
`define MCUID_NIB_HI    7:4
`define MCUID_NIB_LO    3:0

// groups and opcodes
`define MCUID_GRP_BYTE  2'h0
`define MCUID_GRP_BIT   2'h1
`define MCUID_GRP_JUMP  2'h2
`define MCUID_GRP_LIT   2'h3
`define MCUID_OP_CTL    4'h0
`define MCUID_OP_CLR    4'h1
`define MCUID_OP_SUB    4'h2
`define MCUID_OP_DEC    4'h3
`define MCUID_OP_IOR    4'h4
`define MCUID_OP_AND    4'h5
`define MCUID_OP_XOR    4'h6
`define MCUID_OP_ADD    4'h7
`define MCUID_OP_MOV    4'h8
`define MCUID_OP_COM    4'h9
`define MCUID_OP_INC    4'hA
`define MCUID_OP_DECSZ  4'hB
`define MCUID_OP_RRF    4'hC
`define MCUID_OP_RLF    4'hD
`define MCUID_OP_SWAP   4'hE
`define MCUID_OP_INCSZ  4'hF
`define MCUID_BOP_CLR   2'h0
`define MCUID_BOP_SET   2'h1
`define MCUID_BOP_TSC   2'h2
`define MCUID_BOP_TSS   2'h3
`define MCUID_CTL_RET   8'h08
`define MCUID_CTL_RETI  8'h09
`define MCUID_CTL_SLP   8'h63
`define MCUID_CTL_WDT   8'h64
`define MCUID_LIT_MOV   2'h0
`define MCUID_LIT_RET   2'h1
`define MCUID_LIT_IOR   4'h8
`define MCUID_LIT_AND   4'h9
`define MCUID_LIT_XOR   4'hA
`define MCUID_LIT_SUB   3'h6
`define MCUID_LIT_ADD   3'h7
`define MCUID_IDLE_WORD 14'h0000

// file map
`define MCUID_TIMER_ZERO_COUNT_ADDR 7'h01
`define MCUID_PORT_LO   7'h05
`define MCUID_PORT_HI   7'h09

// software port, reset values and return stack
`define MCUID_REG_CTRL  2'h0
`define MCUID_REG_STAT  2'h1
`define MCUID_REG_PC    2'h2
`define MCUID_REG_IR    2'h3
`define MCUID_CTRL_PSA  0
`define MCUID_CTRL_RST  1'b0
`define MCUID_PC_RST    13'h0000
`define MCUID_STK_AW    3
`define MCUID_STK_N     8

`endif

// [hdl/mcuid_pkg.sv]
package mcuid_pkg;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mcuid_phase_t;
  typedef struct packed {
    logic to;
    logic pd;
    logic z;
    logic dc;
    logic c;
  } mcuid_flags_t;
endpackage : mcuid_pkg

// [hdl/mcuid_core.sv]
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mcuid_cfg.svh"

// How it works
// - 14-bit word split into opcode and operands
// - d=0 result to accumulator, d=1 to file
// - file operand is 7 bits, 0x00-0x7F
// - 8-bit literals; call/jump prefix 10, 11-bit target
// - one instruction cycle is four clock phases
// - skips and jumps take two cycles, second idle
// - file operand always read before modify and store
// - port self-modify reads pin levels
// - timer zero write clears assigned prescaler
// - add and subtract set carry, half carry, zero
// - or, xor, and, complement set only zero
// - inc/dec set zero; skip forms keep flags
// - rotates go through carry, change only carry
// - bit clear, set, and flag-free bit tests
// - returns take two cycles; literal return loads accumulator
// - watchdog clear and standby update expiry, sleep flags
// - literal logic sets zero; literal load keeps flags
// - don't-care bits ignored either value
module mcuid_core
  import mcuid_pkg::*;
(
  // clock and reset
  input  wire logic                   SYS_CLK,
  input  wire logic                   RESET_N,
  // program memory
  output logic [`MCUID_PCW-1:0]       PROG_ADDR,
  input  wire logic [`MCUID_IW-1:0]   PROG_DATA,
  // register file
  output logic [6:0]                  FILE_ADDR,
  output logic                        FILE_RD,
  input  wire logic [7:0]             FILE_RDATA,
  output logic                        FILE_WR,
  output logic [7:0]                  FILE_WDATA,
  input  wire logic [7:0]             PIN_LEVELS,
  // core state and side effects
  output logic [7:0]                  ACC,
  output mcuid_flags_t                FLAGS,
  output logic                        PRESC_CLR,
  output logic                        WDT_CLR,
  output logic                        SLEEP_REQ,
  output logic                        INT_RETURN,
  // software port
  input  wire logic [1:0]             BUS_ADDR,
  input  wire logic [15:0]            BUS_WDATA,
  input  wire logic                   BUS_WR,
  input  wire logic                   BUS_RD,
  output logic [15:0]                 BUS_RDATA
);

  mcuid_phase_t           phase_reg;
  logic [`MCUID_IW-1:0]   ir_reg;
  logic [`MCUID_PCW-1:0]  pc_reg;
  logic [`MCUID_PCW-1:0]  pc_next;
  logic [7:0]             w_reg;
  mcuid_flags_t           flags_reg;
  mcuid_flags_t           flags_next;
  logic [6:0]             fa_reg;
  logic                   frd_reg;
  logic                   fwr_reg;
  logic [7:0]             fwd_reg;
  logic                   flush_reg;
  logic                   hold_pc_reg;
  logic                   presc_reg;
  logic                   wdt_reg;
  logic                   slp_reg;
  logic                   reti_reg;
  logic                   psa_reg;
  logic [15:0]            rdata_reg;
  logic [7:0]             pin_s1_reg;
  logic [7:0]             pin_s2_reg;
  logic [`MCUID_PCW-1:0]  stack_mem [`MCUID_STK_N];
  logic [`MCUID_STK_AW-1:0] sp_reg;

  // field decode
  wire [1:0] grp      = ir_reg[`MCUID_F_GRP];
  wire [3:0] op       = ir_reg[`MCUID_F_OP];
  wire       dbit     = ir_reg[`MCUID_F_D];
  wire [6:0] faddr    = ir_reg[`MCUID_F_FILE];
  wire [1:0] bop      = ir_reg[`MCUID_F_BOP];
  wire [2:0] bsel     = ir_reg[`MCUID_F_BIT];
  wire [7:0] k8       = ir_reg[`MCUID_F_K8];
  wire [`MCUID_PCW-1:0] k11 = {2'h0, ir_reg[`MCUID_F_K11]};
  wire [7:0] ctl      = ir_reg[`MCUID_F_CTL];
  wire       is_byte  = grp == `MCUID_GRP_BYTE;
  wire       is_bit   = grp == `MCUID_GRP_BIT;
  wire       is_jump  = grp == `MCUID_GRP_JUMP;
  wire       is_lit   = grp == `MCUID_GRP_LIT;
  wire       is_ctl   = is_byte && op == `MCUID_OP_CTL && !dbit;
  wire       is_clrw  = is_byte && op == `MCUID_OP_CLR && !dbit;
  wire       is_call  = is_jump && !ir_reg[`MCUID_F_JSEL];
  wire       is_ret   = is_ctl && ctl == `MCUID_CTL_RET;
  wire       is_reti  = is_ctl && ctl == `MCUID_CTL_RETI;
  wire       is_wdt   = is_ctl && ctl == `MCUID_CTL_WDT;
  wire       is_slp   = is_ctl && ctl == `MCUID_CTL_SLP;
  wire       is_return_literal_op = is_lit && ir_reg[`MCUID_F_L2] == `MCUID_LIT_RET;
  wire       is_load_literal_op = is_lit && ir_reg[`MCUID_F_L2] == `MCUID_LIT_MOV;
  wire       is_skop  = is_byte && (op == `MCUID_OP_DECSZ || op == `MCUID_OP_INCSZ);
  wire       uses_file = (is_byte && !is_ctl && !is_clrw) || is_bit;
  wire       is_port  = fa_reg >= `MCUID_PORT_LO && fa_reg <= `MCUID_PORT_HI;
  wire [7:0] opnd     = is_port ? pin_s2_reg : FILE_RDATA;
  wire [7:0] bmask    = 8'h01 << bsel;

  // adder shared by add and subtract forms
  wire       do_sub   = (is_byte && op == `MCUID_OP_SUB) ||
                        (is_lit && ir_reg[`MCUID_F_L3] == `MCUID_LIT_SUB);
  wire [7:0] add_a    = is_lit ? k8 : opnd;
  wire [7:0] add_b    = do_sub ? ~w_reg : w_reg;
  wire [8:0] sum9     = {1'b0, add_a} + {1'b0, add_b} + {8'h00, do_sub};
  wire [4:0] sum5     = {1'b0, add_a[`MCUID_NIB_LO]} + {1'b0, add_b[`MCUID_NIB_LO]} + {4'h0, do_sub};

  logic [7:0] res;
  logic       to_w;
  logic       to_f;
  logic       set_z;
  logic       set_cdc;
  logic       set_c;
  logic       c_rot;
  logic       skip;
  logic       jump;

  always_comb begin
    res     = opnd;
    to_w    = 1'b0;
    to_f    = 1'b0;
    set_z   = 1'b0;
    set_cdc = 1'b0;
    set_c   = 1'b0;
    c_rot   = flags_reg.c;
    skip    = 1'b0;
    jump    = 1'b0;
    unique case (grp)
      `MCUID_GRP_BYTE: begin
        to_w  = !dbit;
        to_f  = dbit;
        set_z = 1'b1;
        unique case (op)
          `MCUID_OP_CTL: begin
            res   = w_reg;
            to_w  = 1'b0;
            set_z = 1'b0;
            jump  = is_ret || is_reti;
          end
          `MCUID_OP_CLR:   res = 8'h00;
          `MCUID_OP_SUB, `MCUID_OP_ADD: begin
            res     = sum9[7:0];
            set_cdc = 1'b1;
          end
          `MCUID_OP_DEC:   res = opnd - 8'h01;
          `MCUID_OP_INC:   res = opnd + 8'h01;
          `MCUID_OP_IOR:   res = opnd | w_reg;
          `MCUID_OP_AND:   res = opnd & w_reg;
          `MCUID_OP_XOR:   res = opnd ^ w_reg;
          `MCUID_OP_COM:   res = ~opnd;
          `MCUID_OP_MOV:   res = opnd;
          `MCUID_OP_DECSZ, `MCUID_OP_INCSZ: begin
            res   = (op == `MCUID_OP_DECSZ) ? opnd - 8'h01 : opnd + 8'h01;
            set_z = 1'b0;
            skip  = res == 8'h00;
          end
          `MCUID_OP_RRF, `MCUID_OP_RLF: begin
            res   = (op == `MCUID_OP_RLF) ? {opnd[6:0], flags_reg.c} : {flags_reg.c, opnd[7:1]};
            c_rot = (op == `MCUID_OP_RLF) ? opnd[`MCUID_MSB] : opnd[`MCUID_LSB];
            set_c = 1'b1;
            set_z = 1'b0;
          end
          `MCUID_OP_SWAP: begin
            res   = {opnd[`MCUID_NIB_LO], opnd[`MCUID_NIB_HI]};
            set_z = 1'b0;
          end
        endcase
        if (is_ctl) begin
          to_f = 1'b0;
        end else if (op == `MCUID_OP_CTL) begin
          to_f = 1'b1;
        end
      end
      `MCUID_GRP_BIT: begin
        unique case (bop)
          `MCUID_BOP_CLR: begin res = opnd & ~bmask; to_f = 1'b1; end
          `MCUID_BOP_SET: begin res = opnd | bmask;  to_f = 1'b1; end
          `MCUID_BOP_TSC: skip = (opnd & bmask) == 8'h00;
          `MCUID_BOP_TSS: skip = (opnd & bmask) != 8'h00;
        endcase
      end
      `MCUID_GRP_JUMP: jump = 1'b1;
      `MCUID_GRP_LIT: begin
        to_w  = 1'b1;
        set_z = 1'b1;
        res   = k8;
        if (is_load_literal_op || is_return_literal_op) begin
          set_z = 1'b0;
          jump  = is_return_literal_op;
        end else if (ir_reg[`MCUID_F_L3] == `MCUID_LIT_SUB || ir_reg[`MCUID_F_L3] == `MCUID_LIT_ADD) begin
          res     = sum9[7:0];
          set_cdc = 1'b1;
        end else if (op == `MCUID_LIT_IOR) begin
          res = k8 | w_reg;
        end else if (op == `MCUID_LIT_AND) begin
          res = k8 & w_reg;
        end else if (op == `MCUID_LIT_XOR) begin
          res = k8 ^ w_reg;
        end else begin
          to_w  = 1'b0;
          set_z = 1'b0;
        end
      end
    endcase
  end

  // flag and program counter updates at commit
  always_comb begin
    flags_next = flags_reg;
    if (set_z) flags_next.z = res == 8'h00;
    if (set_cdc) begin
      flags_next.c  = sum9[8];
      flags_next.dc = sum5[4];
    end
    if (set_c) flags_next.c = c_rot;
    if (is_wdt || is_slp) begin
      flags_next.to = 1'b1;
      flags_next.pd = !is_slp;
    end
  end

  wire [`MCUID_STK_AW-1:0] sp_dec  = sp_reg - 1'b1;
  assign pc_next = is_jump ? k11 : (is_ret || is_reti || is_return_literal_op) ? stack_mem[sp_dec] : pc_reg;
  wire commit = phase_reg == PH_Q3;
  wire fwr_go = commit && to_f && uses_file;
  wire [15:0] stat_word = {3'h0, flags_reg, w_reg};
  wire [15:0] rd_sel = (BUS_ADDR == `MCUID_REG_CTRL) ? {15'h0000, psa_reg} :
                       (BUS_ADDR == `MCUID_REG_STAT) ? stat_word :
                       (BUS_ADDR == `MCUID_REG_PC)   ? {3'h0, pc_reg} : {2'h0, ir_reg};

  // four-phase sequencer
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_reg <= PH_Q1;
    end else begin
      unique case (phase_reg)
        PH_Q1: phase_reg <= PH_Q2;
        PH_Q2: phase_reg <= PH_Q3;
        PH_Q3: phase_reg <= PH_Q4;
        PH_Q4: phase_reg <= PH_Q1;
      endcase
    end
  end

  // fetch and flow
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ir_reg      <= `MCUID_IDLE_WORD;
      pc_reg      <= `MCUID_PC_RST;
      sp_reg      <= '0;
      flush_reg   <= 1'b0;
      hold_pc_reg <= 1'b0;
    end else if (commit) begin
      flush_reg   <= skip || jump;
      hold_pc_reg <= jump;
      pc_reg      <= pc_next;
      if (is_call) begin
        stack_mem[sp_reg] <= pc_reg;
        sp_reg            <= sp_reg + 1'b1;
      end else if (is_ret || is_reti || is_return_literal_op) begin
        sp_reg <= sp_dec;
      end
    end else if (phase_reg == PH_Q4) begin
      ir_reg    <= flush_reg ? `MCUID_IDLE_WORD : PROG_DATA;
      pc_reg    <= hold_pc_reg ? pc_reg : pc_reg + 1'b1;
      flush_reg <= 1'b0;
      hold_pc_reg <= 1'b0;
    end
  end

  // file access: read in Q2, data in Q3, store in Q4
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fa_reg  <= '0;
      frd_reg <= 1'b0;
      fwr_reg <= 1'b0;
      fwd_reg <= '0;
    end else begin
      if (phase_reg == PH_Q1) fa_reg <= faddr;
      frd_reg <= phase_reg == PH_Q1 && uses_file;
      fwr_reg <= fwr_go;
      if (fwr_go) fwd_reg <= res;
    end
  end

  // accumulator, flags, side-effect pulses
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      w_reg     <= '0;
      flags_reg <= '{to: 1'b1, pd: 1'b1, default: 1'b0};
      presc_reg <= 1'b0;
      wdt_reg   <= 1'b0;
      slp_reg   <= 1'b0;
      reti_reg  <= 1'b0;
    end else begin
      if (commit && to_w) w_reg <= res;
      if (commit) flags_reg <= flags_next;
      presc_reg <= fwr_go && fa_reg == `MCUID_TIMER_ZERO_COUNT_ADDR && psa_reg;
      wdt_reg   <= commit && is_wdt;
      slp_reg   <= commit && is_slp;
      reti_reg  <= commit && is_reti;
    end
  end

  // pin synchroniser and software port
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      psa_reg    <= `MCUID_CTRL_RST;
      rdata_reg  <= '0;
    end else begin
      pin_s1_reg <= PIN_LEVELS;
      pin_s2_reg <= pin_s1_reg;
      if (BUS_WR && BUS_ADDR == `MCUID_REG_CTRL) psa_reg <= BUS_WDATA[`MCUID_CTRL_PSA];
      rdata_reg  <= BUS_RD ? rd_sel : 16'h0000;
    end
  end

  assign PROG_ADDR  = pc_reg;
  assign FILE_ADDR  = fa_reg;
  assign FILE_RD    = frd_reg;
  assign FILE_WR    = fwr_reg;
  assign FILE_WDATA = fwd_reg;
  assign ACC        = w_reg;
  assign FLAGS      = flags_reg;
  assign PRESC_CLR  = presc_reg;
  assign WDT_CLR    = wdt_reg;
  assign SLEEP_REQ  = slp_reg;
  assign INT_RETURN = reti_reg;
  assign BUS_RDATA  = rdata_reg;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  phase_order_a: assert property (phase_reg == PH_Q1 |=> phase_reg == PH_Q2 ##1 phase_reg == PH_Q3
    ##1 phase_reg == PH_Q4 ##1 phase_reg == PH_Q1) else $error("phase order broken");
  read_phase_a: assert property (FILE_RD |-> phase_reg == PH_Q2) else $error("file read off phase");
  read_first_a: assert property (FILE_WR |-> $past(FILE_RD, 2)) else $error("write without read");
  dest_acc_a: assert property (commit && is_byte && !is_ctl && !dbit |=> !FILE_WR) else $error("d=0 wrote file");
  presc_clr_a: assert property (FILE_WR && FILE_ADDR == `MCUID_TIMER_ZERO_COUNT_ADDR && $past(psa_reg) |-> PRESC_CLR)
    else $error("prescaler not cleared");
  jump_idle_a: assert property (commit && is_jump |=> ##1 ir_reg == `MCUID_IDLE_WORD) else $error("no idle cycle");
  jump_target_a: assert property (commit && is_jump |=> PROG_ADDR == $past(k11)) else $error("bad jump target");
  skip_flags_a: assert property (commit && is_skop |=> $stable(FLAGS)) else $error("skip op changed flags");
  sleep_flags_a: assert property (commit && is_slp |=> FLAGS.to && !FLAGS.pd && SLEEP_REQ)
    else $error("standby flags wrong");
  load_lit_a: assert property (commit && is_load_literal_op |=> ACC == $past(k8) && $stable(FLAGS))
    else $error("literal load wrong");

endmodule : mcuid_core
`default_nettype wire

// [tb/test_mcuid_core.sv]
`timescale 1ns/1ps
`default_nettype none
module test_mcuid_core
  import mcuid_pkg::*;
;
  logic         sys_clk    = 1'b0;
  logic         reset_n    = 1'b0;
  logic [12:0]  prog_addr;
  logic [13:0]  rom [0:31] = '{default: 14'h0000};
  logic [6:0]   file_addr;
  logic         file_rd;
  logic         file_wr;
  logic [7:0]   file_rdata = 8'h00;
  logic [7:0]   file_wdata;
  logic [7:0]   fmem [0:127];
  logic         rd_seen [0:127];
  logic [7:0]   pins       = 8'hA5;
  logic [7:0]   acc;
  mcuid_flags_t flags;
  wire  [3:0]   side;
  logic [15:0]  side_n;
  logic [1:0]   bus_addr   = 2'h0;
  logic [15:0]  bus_wdata  = 16'h0000;
  logic         bus_wr     = 1'b0;
  logic         bus_rd     = 1'b0;
  logic [15:0]  bus_rdata;
  int           cyc;
  int           t_first;
  int           t_last;
  int           mismatches = 0;
  int           num_checks = 0;

  mcuid_core i_mcuid_core (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .PROG_ADDR(prog_addr), .PROG_DATA(rom[prog_addr[4:0]]),
    .FILE_ADDR(file_addr), .FILE_RD(file_rd), .FILE_RDATA(file_rdata), .FILE_WR(file_wr),
    .FILE_WDATA(file_wdata), .PIN_LEVELS(pins), .ACC(acc), .FLAGS(flags), .PRESC_CLR(side[0]),
    .WDT_CLR(side[1]), .SLEEP_REQ(side[2]), .INT_RETURN(side[3]), .BUS_ADDR(bus_addr),
    .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata)
  );

  always #10 sys_clk = ~sys_clk;

  // register file: data only in the cycle after a read strobe
  always @(posedge sys_clk) begin
    file_rdata <= file_rd ? fmem[file_addr] : ~file_rdata;
    if (file_rd) rd_seen[file_addr] <= 1'b1;
    if (file_wr) fmem[file_addr] <= file_wdata;
  end

  // side pulse counts and read timestamps
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      side_n <= 16'h0000;
      cyc <= 0;
      t_first <= 0;
      t_last <= 0;
    end else begin
      cyc <= cyc + 1;
      for (int i = 0; i < 4; i++) side_n[i*4 +: 4] <= side_n[i*4 +: 4] + 4'(side[i]);
      if (file_rd && file_addr == 7'h30 && t_first == 0) t_first <= cyc;
      if (file_rd && file_addr == 7'h46) t_last <= cyc;
    end
  end

  function automatic logic [13:0] bw(logic [3:0] op, logic d, logic [6:0] f);
    return {2'b00, op, d, f};
  endfunction : bw

  function automatic logic [13:0] bb(logic [1:0] op, logic [2:0] b, logic [6:0] f);
    return {2'b01, op, b, f};
  endfunction : bb

  function automatic logic [13:0] lw(logic [3:0] op, logic [7:0] k);
    return {2'b11, op, k};
  endfunction : lw

  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic start(logic [13:0] p [$]);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    foreach (rom[i]) rom[i] = (i < p.size()) ? p[i] : 14'h0000;
    foreach (rd_seen[i]) rd_seen[i] = 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask : start

  task automatic finish_at(logic [12:0] a);
    int n;
    n = 0;
    while (prog_addr !== a && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 500) begin
      mismatches++;
      close_out();
    end else begin
      repeat (16) @(posedge sys_clk);
      #1;
    end
  endtask : finish_at

  task automatic reg_write(logic [1:0] a, logic [15:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(logic [1:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : reg_read

  // arithmetic and logic, don't-care bits set to one
  task automatic t_alu();
    fmem[7'h21] = 8'h05;
    fmem[7'h22] = 8'h05;
    fmem[7'h23] = 8'hFF;
    start('{lw(4'h3, 8'h0F), lw(4'hF, 8'h01), bw(4'h0, 1'b1, 7'h7F), bw(4'h7, 1'b1, 7'h7F), lw(4'hD, 8'h10),
            lw(4'h8, 8'h00), bw(4'h2, 1'b0, 7'h21), bw(4'h6, 1'b1, 7'h22), bw(4'h9, 1'b0, 7'h23),
            lw(4'h8, 8'h3C), lw(4'h9, 8'h0F), bw(4'h4, 1'b1, 7'h22), bw(4'h5, 1'b0, 7'h22), lw(4'hA, 8'h0C),
            14'h280E});
    finish_at(13'h000E);
    chk("acc", 16'(acc), 16'h0000);
    chk("flags", 16'(flags), 16'h001F);
    chk("f7f", 16'(fmem[7'h7F]), 16'h0020);
    chk("f21", 16'(fmem[7'h21]), 16'h0005);
    chk("f22", 16'(fmem[7'h22]), 16'h000C);
  endtask : t_alu

  // rotates, inc/dec, swap, clears
  task automatic t_shift();
    fmem[7'h24] = 8'h01;
    fmem[7'h25] = 8'h80;
    fmem[7'h26] = 8'hFF;
    fmem[7'h27] = 8'h02;
    fmem[7'h28] = 8'h3C;
    fmem[7'h29] = 8'hAA;
    start('{bw(4'h0, 1'b1, 7'h01), bw(4'h1, 1'b0, 7'h7F), bw(4'hC, 1'b1, 7'h24), bw(4'hD, 1'b0, 7'h25),
            bw(4'hA, 1'b1, 7'h26), bw(4'h3, 1'b0, 7'h27), bw(4'hE, 1'b1, 7'h28), bw(4'h1, 1'b1, 7'h29),
            14'h0060, lw(4'hB, 8'h55), 14'h280A});
    finish_at(13'h000A);
    chk("acc", 16'(acc), 16'h0001);
    chk("flags", 16'(flags), 16'h001D);
    chk("f24", 16'(fmem[7'h24]), 16'h0000);
    chk("f25", 16'(fmem[7'h25]), 16'h0080);
    chk("f28", 16'(fmem[7'h28]), 16'h00C3);
    chk("f29", 16'(fmem[7'h29]), 16'h0000);
    chk("rd29", 16'(rd_seen[7'h29]), 16'h0001);
    chk("presc", side_n, 16'h0000);
  endtask : t_shift

  // bit ops, skips, call and literal return, cycle count
  task automatic t_flow();
    logic [7:0] ex [0:6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h01, 8'h01};
    fmem[7'h30] = 8'h00;
    fmem[7'h31] = 8'hFF;
    foreach (ex[i]) fmem[7'h40 + i] = (i == 2) ? 8'h01 : (i == 4) ? 8'hFE : 8'h00;
    start('{bb(2'h1, 3'd3, 7'h30), bb(2'h0, 3'd0, 7'h31), bb(2'h2, 3'd3, 7'h30), bw(4'hA, 1'b1, 7'h40),
            bb(2'h3, 3'd3, 7'h30), bw(4'hA, 1'b1, 7'h41), bw(4'hB, 1'b1, 7'h42), bw(4'hA, 1'b1, 7'h43),
            bw(4'hF, 1'b1, 7'h44), bw(4'hA, 1'b1, 7'h45), 14'h2014, bw(4'hA, 1'b1, 7'h46), 14'h280C});
    rom[20] = lw(4'h7, 8'h5A);
    finish_at(13'h000C);
    chk("acc", 16'(acc), 16'h005A);
    chk("f30", 16'(fmem[7'h30]), 16'h0008);
    chk("f31", 16'(fmem[7'h31]), 16'h00FE);
    foreach (ex[i]) chk("f4x", 16'(fmem[7'h40 + i]), 16'(ex[i]));
    chk("cycles", 16'(t_last - t_first), 16'd56);
  endtask : t_flow

  // prescaler clear, port read-back, control words, software port
  task automatic t_side();
    logic [15:0] d;
    fmem[7'h06] = 8'h3C;
    start('{bw(4'h0, 1'b1, 7'h01), bw(4'h8, 1'b1, 7'h06), 14'h2006, 14'h0063, 14'h0064, 14'h2805, 14'h2008,
            14'h0009, 14'h0008});
    reg_write(2'h0, 16'h0001);
    finish_at(13'h0005);
    chk("pulses", side_n, 16'h1111);
    chk("f06", 16'(fmem[7'h06]), 16'h00A5);
    chk("flags", 16'(flags), 16'h0018);
    reg_read(2'h1, d);
    chk("stat", d, 16'h1800);
    reg_read(2'h0, d);
    chk("ctrl", d, 16'h0001);
    @(posedge sys_clk);
    #1 chk("idle_rd", bus_rdata, 16'h0000);
  endtask : t_side

  initial begin
    t_alu();
    t_shift();
    t_flow();
    t_side();
    close_out();
  end
endmodule : test_mcuid_core
`default_nettype wire
